/* pfc_cmd_assertions.sv */
// pfc_cmd_assertions.sv: port-level checks of the command register block.
// assumes: bound into pfc_cmd_top; one clock, async active-low reset.

`timescale 1ns/1ps

`include "pfc_regs.svh"

module pfc_cmd_assertions
#(
   parameter pfc_pkg::pfc_word_t SOCKET_IDENT = 16'h5a01
)
(
   input wire logic                clk,
   input wire logic                rst_n,
   input wire logic                cfg_rd,
   input wire logic                cfg_wr,
   input wire logic [1:0]          cfg_func,
   input wire logic [7:0]          cfg_addr,
   input wire pfc_pkg::pfc_word_t  cfg_rdata,
   input wire logic                cfg_ack,
   input wire logic                rev23_features_enable,
   input wire pfc_pkg::pfc_fmask_t io_decode_hit,
   input wire pfc_pkg::pfc_fmask_t mem_decode_hit,
   input wire pfc_pkg::pfc_fmask_t io_claim,
   input wire pfc_pkg::pfc_fmask_t mem_claim,
   input wire logic                special_claim,
   input wire pfc_pkg::pfc_fmask_t init_req,
   input wire pfc_pkg::pfc_fmask_t bus_req,
   input wire logic                init_use_winv,
   input wire pfc_pkg::pfc_fmask_t int_req,
   input wire pfc_pkg::pfc_fmask_t int_assert,
   input wire pfc_pkg::pfc_fmask_t palette_wr_hit,
   input wire pfc_pkg::pfc_fmask_t palette_claim,
   input wire pfc_pkg::pfc_fmask_t snoop_valid,
   input wire logic                addr_par_err,
   input wire logic                data_par_err,
   input wire logic                serr_o,
   input wire logic                serr_oe,
   input wire logic                perr_o,
   input wire logic                perr_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // decode of identification and command reads
   wire id_rd  = cfg_rd && cfg_func == `PFC_IDENT_FUNC &&
                 cfg_addr == `PFC_OFS_IDENT;
   wire cmd_rd = cfg_rd && cfg_func != 2'h3 && cfg_addr == `PFC_OFS_CMD;

   // ****************************************************************
   // assertions
   // ****************************************************************
   AST_ACK: assert property (cfg_ack == $past(cfg_rd || cfg_wr))
      else $error("ack not one cycle after strobe");
   AST_IDENT: assert property ($past(id_rd) |-> cfg_rdata == SOCKET_IDENT)
      else $error("identification read wrong");
   AST_RO_BITS: assert property ($past(cmd_rd) |-> (cfg_rdata & 16'hfa98) == 16'h0000)
      else $error("read-only command bit set");
   AST_INT_BLOCK_RO: assert property ($past(cmd_rd && !rev23_features_enable) && !$past(rev23_features_enable, 2) |-> !cfg_rdata[10])
      else $error("interrupt block bit set while features off");
   AST_FIXED_OUT: assert property (!special_claim && !init_use_winv && !serr_o && !perr_o)
      else $error("fixed output not zero");
   AST_SERR_CAUSE: assert property (serr_oe |-> $past(addr_par_err || data_par_err))
      else $error("system error without parity error");
   AST_PERR_CAUSE: assert property (perr_oe |-> $past(data_par_err))
      else $error("parity error line without data error");
   AST_DATA_BOTH: assert property (serr_oe && $past(data_par_err) |-> perr_oe)
      else $error("data error drove system error alone");
   AST_DECODE: assert property ((io_claim & ~$past(io_decode_hit)) == 3'h0 && (mem_claim & ~$past(mem_decode_hit)) == 3'h0)
      else $error("claim without decode hit");
   AST_REQ_INT: assert property ((bus_req & ~$past(init_req)) == 3'h0 && (int_assert & ~$past(int_req)) == 3'h0)
      else $error("request or interrupt without cause");
   AST_PALETTE: assert property ((palette_claim | snoop_valid) == $past(palette_wr_hit) && (palette_claim & snoop_valid) == 3'h0)
      else $error("palette write neither claimed nor snooped once");

   // main scenarios reached
   cover property (serr_oe && perr_oe);
   cover property (snoop_valid != 3'h0);
   cover property ($past(id_rd) && cfg_ack);
endmodule

bind pfc_cmd_top pfc_cmd_assertions #(.SOCKET_IDENT(SOCKET_IDENT))
   pfc_cmd_assertions_inst
(
   .clk(clk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
   .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
   .cfg_ack(cfg_ack), .rev23_features_enable(rev23_features_enable),
   .io_decode_hit(io_decode_hit), .mem_decode_hit(mem_decode_hit),
   .io_claim(io_claim), .mem_claim(mem_claim),
   .special_claim(special_claim), .init_req(init_req), .bus_req(bus_req),
   .init_use_winv(init_use_winv), .int_req(int_req),
   .int_assert(int_assert), .palette_wr_hit(palette_wr_hit),
   .palette_claim(palette_claim), .snoop_valid(snoop_valid),
   .addr_par_err(addr_par_err), .data_par_err(data_par_err),
   .serr_o(serr_o), .serr_oe(serr_oe), .perr_o(perr_o), .perr_oe(perr_oe)
);

/* pfc_cmd_reg.sv */
// pfc_cmd_reg.sv: the command register of one function.
// assumes: the caller qualifies wr_en with offset and function decode.

`timescale 1ns/1ps

`include "pfc_regs.svh"

module pfc_cmd_reg
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             wr_en,
   input  wire logic [1:0]       be,
   input  wire pfc_pkg::pfc_word_t wdata,
   input  wire logic             rev23_features_enable,
   output pfc_pkg::pfc_word_t    cmd_q
);

   pfc_pkg::pfc_word_t cmd_d;
   pfc_pkg::pfc_word_t merged;
   pfc_pkg::pfc_word_t masked;

   // byte-lane merge of the write data over the held value
   assign merged = {be[1] ? wdata[15:8] : cmd_q[15:8],
                    be[0] ? wdata[7:0]  : cmd_q[7:0]};

   // read-only and reserved bits stay at zero whatever is written
   assign masked = merged & `PFC_CMD_WR_MASK;

   // next value: write, then interrupt block held off without rev 2.3
   always_comb
   begin
      cmd_d = wr_en ? masked : cmd_q;
      cmd_d[`PFC_BIT_INT_BLOCK] = cmd_d[`PFC_BIT_INT_BLOCK] &
                                  rev23_features_enable;
   end

   // the register itself
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cmd_q <= `PFC_CMD_RESET;
      else
         cmd_q <= cmd_d;
   end

endmodule

/* pfc_cmd_top.sv */
// pfc_cmd_top.sv: three command registers, socket identification and
// the gating that the command bits apply to the bus paths.
// assumes: a bus engine that turns configuration cycles into one-cycle
// cfg_rd / cfg_wr strobes and reports decode hits as one-cycle pulses.

`timescale 1ns/1ps

`include "pfc_regs.svh"

module pfc_cmd_top
#(
   // identification value is arbitrary
   parameter pfc_pkg::pfc_word_t SOCKET_IDENT = 16'h5a01
)
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   // configuration access
   input  wire logic               cfg_rd,
   input  wire logic               cfg_wr,
   input  wire logic [1:0]         cfg_func,
   input  wire logic [7:0]         cfg_addr,
   input  wire logic [1:0]         cfg_be,
   input  wire pfc_pkg::pfc_word_t cfg_wdata,
   output pfc_pkg::pfc_word_t      cfg_rdata,
   output logic                    cfg_ack,
   // global control from the general control register
   input  wire logic               rev23_features_enable,
   // target decode hits and the resulting claims
   input  wire pfc_pkg::pfc_fmask_t io_decode_hit,
   input  wire pfc_pkg::pfc_fmask_t mem_decode_hit,
   input  wire logic               special_cycle_hit,
   output pfc_pkg::pfc_fmask_t     io_claim,
   output pfc_pkg::pfc_fmask_t     mem_claim,
   output logic                    special_claim,
   // initiator requests
   input  wire pfc_pkg::pfc_fmask_t init_req,
   output pfc_pkg::pfc_fmask_t     bus_req,
   output logic                    init_use_winv,
   // interrupts
   input  wire pfc_pkg::pfc_fmask_t int_req,
   output pfc_pkg::pfc_fmask_t     int_assert,
   // palette writes
   input  wire pfc_pkg::pfc_fmask_t palette_wr_hit,
   input  wire logic [7:0]         palette_wdata,
   output pfc_pkg::pfc_fmask_t     palette_claim,
   output pfc_pkg::pfc_fmask_t     snoop_valid,
   output logic [7:0]              snoop_data,
   // parity errors seen by the bus engine
   input  wire logic               addr_par_err,
   input  wire logic               data_par_err,
   output logic                    serr_o,
   output logic                    serr_oe,
   output logic                    perr_o,
   output logic                    perr_oe
);

   // ****************************************************************
   // decode helpers
   // ****************************************************************

   // one-hot select of a function number, zero for the unused number
   function automatic pfc_pkg::pfc_fmask_t func_onehot
   (
      input logic [1:0] f
   );
      pfc_pkg::pfc_fmask_t sel;
      sel = 3'h0;
      if (f == pfc_pkg::PFC_FUNC_0)
         sel = 3'h1;
      else if (f == pfc_pkg::PFC_FUNC_1)
         sel = 3'h2;
      else if (f == pfc_pkg::PFC_FUNC_2)
         sel = 3'h4;
      return sel;
   endfunction

   // ****************************************************************
   // configuration decode
   // ****************************************************************

   pfc_pkg::pfc_fmask_t rd_sel;
   pfc_pkg::pfc_fmask_t wr_sel;
   logic                hit_cmd;
   logic                hit_ident;

   // offset and function decode of the current cycle
   assign hit_cmd   = (cfg_addr == `PFC_OFS_CMD);
   assign hit_ident = (cfg_addr == `PFC_OFS_IDENT) &&
                      (cfg_func == `PFC_IDENT_FUNC);
   assign rd_sel    = func_onehot(cfg_func);
   assign wr_sel    = func_onehot(cfg_func) &
                      {3{cfg_wr & hit_cmd}};

   // ****************************************************************
   // command registers, one per function
   // ****************************************************************

   pfc_pkg::pfc_word_t  cmd_val [3];
   pfc_pkg::pfc_fmask_t en_io;
   pfc_pkg::pfc_fmask_t en_mem;
   pfc_pkg::pfc_fmask_t en_init;
   pfc_pkg::pfc_fmask_t en_snoop;
   pfc_pkg::pfc_fmask_t en_par;
   pfc_pkg::pfc_fmask_t en_sys;
   pfc_pkg::pfc_fmask_t en_block;
   pfc_pkg::pfc_fmask_t en_winv;
   pfc_pkg::pfc_fmask_t en_special;

   genvar g;

   // each function owns its register and its field taps
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_func
         pfc_cmd_reg u_cmd
         (
            .clk                   (clk),
            .rst_n                 (rst_n),
            .wr_en                 (wr_sel[g]),
            .be                    (cfg_be),
            .wdata                 (cfg_wdata),
            .rev23_features_enable (rev23_features_enable),
            .cmd_q                 (cmd_val[g])
         );

         assign en_io[g]      = cmd_val[g][`PFC_BIT_IO];
         assign en_mem[g]     = cmd_val[g][`PFC_BIT_MEM];
         assign en_init[g]    = cmd_val[g][`PFC_BIT_INIT];
         assign en_snoop[g]   = cmd_val[g][`PFC_BIT_SNOOP];
         assign en_par[g]     = cmd_val[g][`PFC_BIT_PAR_RESP];
         assign en_sys[g]     = cmd_val[g][`PFC_BIT_SYS_ERR];
         assign en_block[g]   = cmd_val[g][`PFC_BIT_INT_BLOCK];
         assign en_winv[g]    = cmd_val[g][`PFC_BIT_WINV];
         assign en_special[g] = cmd_val[g][`PFC_BIT_SPECIAL];
      end
   endgenerate

   // ****************************************************************
   // configuration read path
   // ****************************************************************

   pfc_pkg::pfc_word_t cmd_rd;
   pfc_pkg::pfc_word_t cfg_rdata_d;
   logic               cfg_ack_d;

   // per-function read-back, each copy independent of the others
   assign cmd_rd = (cmd_val[0] & {16{rd_sel[0]}}) |
                   (cmd_val[1] & {16{rd_sel[1]}}) |
                   (cmd_val[2] & {16{rd_sel[2]}});

   // read data: identification, command or zero for unmapped words
   assign cfg_rdata_d = !cfg_rd   ? `PFC_RD_UNMAPPED :
                        hit_ident ? SOCKET_IDENT :
                        hit_cmd   ? cmd_rd : `PFC_RD_UNMAPPED;

   // every read or write is acknowledged one cycle later
   assign cfg_ack_d = cfg_rd | cfg_wr;

   // read data and acknowledge registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_rdata <= `PFC_RD_UNMAPPED;
         cfg_ack   <= 1'b0;
      end
      else
      begin
         cfg_rdata <= cfg_rdata_d;
         cfg_ack   <= cfg_ack_d;
      end
   end

   // ****************************************************************
   // target claims and initiator requests
   // ****************************************************************

   pfc_pkg::pfc_fmask_t io_claim_d;
   pfc_pkg::pfc_fmask_t mem_claim_d;
   pfc_pkg::pfc_fmask_t bus_req_d;
   logic                special_claim_d;
   logic                init_use_winv_d;

   // i/o and memory cycles claimed only with their enables set
   assign io_claim_d  = io_decode_hit & en_io;
   assign mem_claim_d = mem_decode_hit & en_mem;

   // bus requests pass only from functions allowed to initiate
   assign bus_req_d = init_req & en_init;

   // special cycles never claimed
   assign special_claim_d = special_cycle_hit & (|en_special) &
                            1'b0;

   // the initiator always uses plain memory write commands
   assign init_use_winv_d = (|en_winv) & 1'b0;

   // claim and request registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         io_claim      <= 3'h0;
         mem_claim     <= 3'h0;
         bus_req       <= 3'h0;
         special_claim <= 1'b0;
         init_use_winv <= 1'b0;
      end
      else
      begin
         io_claim      <= io_claim_d;
         mem_claim     <= mem_claim_d;
         bus_req       <= bus_req_d;
         special_claim <= special_claim_d;
         init_use_winv <= init_use_winv_d;
      end
   end

   // ****************************************************************
   // interrupts
   // ****************************************************************

   pfc_pkg::pfc_fmask_t int_assert_d;

   // a function with its block bit set keeps its interrupt quiet
   assign int_assert_d = int_req & ~en_block;

   // interrupt output register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         int_assert <= 3'h0;
      else
         int_assert <= int_assert_d;
   end

   // ****************************************************************
   // palette snooping
   // ****************************************************************

   pfc_pkg::pfc_fmask_t palette_claim_d;
   pfc_pkg::pfc_fmask_t snoop_valid_d;
   logic                snoop_any;
   logic [7:0]          snoop_data_d;

   // snooping functions capture the data and leave the write unclaimed
   assign palette_claim_d = palette_wr_hit & ~en_snoop;
   assign snoop_valid_d   = palette_wr_hit & en_snoop;
   assign snoop_any       = |snoop_valid_d;
   assign snoop_data_d    = snoop_any ? palette_wdata : snoop_data;

   // palette claim, capture strobe and held capture data
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         palette_claim <= 3'h0;
         snoop_valid   <= 3'h0;
         snoop_data    <= 8'h00;
      end
      else
      begin
         palette_claim <= palette_claim_d;
         snoop_valid   <= snoop_valid_d;
         snoop_data    <= snoop_data_d;
      end
   end

   // ****************************************************************
   // parity and system error
   // ****************************************************************

   logic sys_err_any;
   logic par_resp_any;

   // enables are shared: any function's copy turns the path on
   assign sys_err_any  = |en_sys;
   assign par_resp_any = |en_par;

   // error line drivers
   pfc_par_err u_par_err
   (
      .clk          (clk),
      .rst_n        (rst_n),
      .sys_err_any  (sys_err_any),
      .par_resp_any (par_resp_any),
      .addr_par_err (addr_par_err),
      .data_par_err (data_par_err),
      .serr_o       (serr_o),
      .serr_oe      (serr_oe),
      .perr_o       (perr_o),
      .perr_oe      (perr_oe)
   );

endmodule

/* pfc_host_model.sv */
// pfc_host_model.sv: configuration master standing in for the host side.
// assumes: one-cycle strobes, answer sampled one cycle after the strobe.

`timescale 1ns/1ps

module pfc_host_model
(
   input  wire logic                clk,
   output logic                     cfg_rd,
   output logic                     cfg_wr,
   output logic [1:0]               cfg_func,
   output logic [7:0]               cfg_addr,
   output logic [1:0]               cfg_be,
   output pfc_pkg::pfc_word_t       cfg_wdata,
   input  wire pfc_pkg::pfc_word_t  cfg_rdata,
   input  wire logic                cfg_ack
);
   // idle bus at time zero
   initial
   begin
      {cfg_rd, cfg_wr, cfg_func, cfg_addr, cfg_be, cfg_wdata} = '0;
   end

   // one access: strobe for one edge, then released lines show inverse
   task automatic xfer(input logic rd, input logic wr, input logic [1:0] f,
                       input logic [7:0] a, input logic [1:0] be,
                       input pfc_pkg::pfc_word_t wd,
                       output pfc_pkg::pfc_word_t rdat);
      @(posedge clk);
      #1;
      {cfg_rd, cfg_wr, cfg_func, cfg_addr, cfg_be, cfg_wdata} =
         {rd, wr, f, a, be, wd};
      @(posedge clk);
      #1;
      {cfg_rd, cfg_wr, cfg_be, cfg_wdata} = {2'b00, ~be, ~wd};
      rdat = cfg_rdata;
   endtask
endmodule

/* pfc_par_err.sv */
// pfc_par_err.sv: drives the system-error and parity-error lines.
// assumes: error inputs are one-cycle pulses from the bus engine.

`timescale 1ns/1ps

`include "pfc_regs.svh"

module pfc_par_err
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic sys_err_any,
   input  wire logic par_resp_any,
   input  wire logic addr_par_err,
   input  wire logic data_par_err,
   output logic      serr_o,
   output logic      serr_oe,
   output logic      perr_o,
   output logic      perr_oe
);

   logic addr_report;
   logic data_report;
   logic perr_report;

   // address parity needs both enables and drives system error
   assign addr_report = addr_par_err & sys_err_any & par_resp_any;

   // data parity errors go out on system error once both the driver and response enables are on
   assign data_report = data_par_err & par_resp_any & sys_err_any;

   // parity error line answers only with the response enable set
   assign perr_report = data_par_err & par_resp_any;

   // open-drain lines: level held low, enable pulses for one cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serr_oe <= 1'b0;
         perr_oe <= 1'b0;
         serr_o  <= 1'b0;
         perr_o  <= 1'b0;
      end
      else
      begin
         serr_oe <= addr_report | data_report;
         perr_oe <= perr_report;
         serr_o  <= 1'b0;
         perr_o  <= 1'b0;
      end
   end

endmodule

/* pfc_pkg.sv */
// pfc_pkg.sv: shared types of the per-function command register block.
// assumes: nothing beyond a SystemVerilog compiler.

package pfc_pkg;

   // one configuration word
   typedef logic [15:0] pfc_word_t;

   // one bit for each of the three functions
   typedef logic [2:0] pfc_fmask_t;

   // function numbers carried by a configuration cycle
   typedef enum logic [1:0]
   {
      PFC_FUNC_0    = 2'h0,
      PFC_FUNC_1    = 2'h1,
      PFC_FUNC_2    = 2'h2,
      PFC_FUNC_NONE = 2'h3
   } pfc_func_t;

endpackage

/* pfc_regs.svh */
// pfc_regs.svh: offsets, field positions, reset values and masks of the
// per-function command registers and the socket function identification.
// assumes: included by bare name from every design file of the block.
//
// Summary of operation
// - socket function shows a fixed 16-bit read-only identification at 02h
// - each of the three functions owns its own command register
// - system-error and parity-response enables are ORed across functions
// - command bits 15 to 11 read as zero
// - interrupt-block bit 10 set stops that function asserting its interrupt
// - interrupt-block bit reads zero while rev 2.3 features are disabled
// - back-to-back enable bit 9 is read-only zero
// - bit 8 enables the system-error output driver, off by default
// - address parity errors reported only when bits 8 and 6 both set
// - command bit 7 reads as zero
// - bit 6 clear ignores parity errors, set responds with parity error line
// - detected data parity errors are signalled on the system-error line when bits 8 and 6 both set
// - palette snoop set: palette writes not claimed but their data captured
// - write-and-invalidate enable bit 4 is hardwired zero, ignores writes
// - special-cycle enable bit 3 is hardwired zero, special cycles ignored
// - function requests the bus only while initiator enable bit 2 is set
// - memory-space cycles claimed only while bit 1 is set
// - i/o-space cycles claimed only while bit 0 is set

`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH

// configuration byte offsets of the 16-bit registers
`define PFC_OFS_IDENT      8'h02
`define PFC_OFS_CMD        8'h04

// function that carries the socket identification register
`define PFC_IDENT_FUNC     2'h1

// command register field positions
`define PFC_BIT_IO         0
`define PFC_BIT_MEM        1
`define PFC_BIT_INIT       2
`define PFC_BIT_SPECIAL    3
`define PFC_BIT_WINV       4
`define PFC_BIT_SNOOP      5
`define PFC_BIT_PAR_RESP   6
`define PFC_BIT_SYS_ERR    8
`define PFC_BIT_B2B        9
`define PFC_BIT_INT_BLOCK  10

// reset value and the set of bits that software can change
`define PFC_CMD_RESET      16'h0000
`define PFC_CMD_WR_MASK    16'h0567

// read value of an unmapped configuration word
`define PFC_RD_UNMAPPED    16'h0000

`endif

/* tb_pfc_cmd_top.sv */
// tb_pfc_cmd_top.sv: self-checking bench of the command register block.
// assumes: pfc_host_model makes the configuration cycles.

`timescale 1ns/1ps

`include "pfc_regs.svh"

module tb_pfc_cmd_top;
   // arbitrary identification value
   localparam pfc_pkg::pfc_word_t ID_VAL = 16'h3c5a;

   typedef struct packed
   {
      logic [1:0]  f;
      logic [1:0]  be;
      logic [15:0] wd;
      logic        rev;
      logic [15:0] exp;
   } pfc_row_t;

   logic                clk, rst_n, rev23_features_enable, special_cycle_hit;
   logic                addr_par_err, data_par_err, cfg_rd, cfg_wr, cfg_ack;
   logic                special_claim, init_use_winv, serr_o, serr_oe;
   logic                perr_o, perr_oe;
   logic [1:0]          cfg_func, cfg_be;
   logic [7:0]          cfg_addr, palette_wdata, snoop_data;
   pfc_pkg::pfc_word_t  cfg_wdata, cfg_rdata, rdat;
   pfc_pkg::pfc_fmask_t io_decode_hit, mem_decode_hit, init_req, int_req;
   pfc_pkg::pfc_fmask_t palette_wr_hit, io_claim, mem_claim, bus_req;
   pfc_pkg::pfc_fmask_t int_assert, palette_claim, snoop_valid;
   int                  fails, tests_run;
   pfc_row_t            rows [5];

   pfc_cmd_top #(.SOCKET_IDENT(ID_VAL)) pfc_cmd_top_inst
   (
      .clk(clk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
      .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
      .rev23_features_enable(rev23_features_enable),
      .io_decode_hit(io_decode_hit), .mem_decode_hit(mem_decode_hit),
      .special_cycle_hit(special_cycle_hit), .io_claim(io_claim),
      .mem_claim(mem_claim), .special_claim(special_claim),
      .init_req(init_req), .bus_req(bus_req), .init_use_winv(init_use_winv),
      .int_req(int_req), .int_assert(int_assert),
      .palette_wr_hit(palette_wr_hit), .palette_wdata(palette_wdata),
      .palette_claim(palette_claim), .snoop_valid(snoop_valid),
      .snoop_data(snoop_data), .addr_par_err(addr_par_err),
      .data_par_err(data_par_err), .serr_o(serr_o), .serr_oe(serr_oe),
      .perr_o(perr_o), .perr_oe(perr_oe)
   );

   pfc_host_model pfc_host_model_inst
   (
      .clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_func(cfg_func),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack)
   );

   // 250 MHz clock
   initial clk = 1'b0;
   always #2 clk = ~clk;

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic stop_test();
      $display("counts: tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input pfc_pkg::pfc_word_t got, exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [1:0] f, input logic [7:0] a,
                     input logic [1:0] be, input pfc_pkg::pfc_word_t d);
      pfc_host_model_inst.xfer(1'b0, 1'b1, f, a, be, d, rdat);
   endtask

   task automatic rd(input logic [1:0] f, input logic [7:0] a,
                     input pfc_pkg::pfc_word_t exp);
      pfc_host_model_inst.xfer(1'b1, 1'b0, f, a, 2'h0, 16'h0000, rdat);
      check(rdat, exp);
   endtask

   // one-cycle pulse on every decode and request input
   task automatic pulse_hits(input pfc_pkg::pfc_fmask_t m);
      @(posedge clk);
      #1;
      {io_decode_hit, mem_decode_hit, init_req, int_req} = {4{m}};
      {palette_wr_hit, palette_wdata, special_cycle_hit} = {m, 8'h5c, 1'b1};
      @(posedge clk);
      #1;
      {io_decode_hit, mem_decode_hit, init_req, int_req} = '0;
      {palette_wr_hit, special_cycle_hit} = '0;
   endtask

   // one-cycle parity error pulse, then error enables compared
   task automatic par(input logic a, input logic d,
                      input pfc_pkg::pfc_word_t exp);
      @(posedge clk);
      #1;
      {addr_par_err, data_par_err} = {a, d};
      @(posedge clk);
      #1;
      {addr_par_err, data_par_err} = 2'b00;
      check({14'h0000, serr_oe, perr_oe}, exp);
   endtask

   // watchdog at about forty times the expected run
   initial
   begin
      #12000;
      fails++;
      stop_test();
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      {fails, tests_run} = '0;
      {rst_n, addr_par_err, data_par_err, special_cycle_hit} = '0;
      {io_decode_hit, mem_decode_hit, init_req, int_req} = '0;
      {palette_wr_hit, palette_wdata, rev23_features_enable} = 12'h001;
      rows[0] = {2'h0, 2'h3, 16'hffff, 1'b1, 16'h0567};
      rows[1] = {2'h1, 2'h3, 16'hffff, 1'b0, 16'h0167};
      rows[2] = {2'h2, 2'h1, 16'hffff, 1'b1, 16'h0067};
      rows[3] = {2'h2, 2'h2, 16'hffff, 1'b1, 16'h0567};
      rows[4] = {2'h1, 2'h3, 16'h0000, 1'b1, 16'h0000};
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      // write and read back each row
      foreach (rows[i])
      begin
         rev23_features_enable = rows[i].rev;
         wr(rows[i].f, `PFC_OFS_CMD, rows[i].be, rows[i].wd);
         rd(rows[i].f, `PFC_OFS_CMD, rows[i].exp);
      end
      rd(2'h0, `PFC_OFS_CMD, 16'h0167);
      wr(2'h1, `PFC_OFS_IDENT, 2'h3, 16'hffff);
      rd(2'h1, `PFC_OFS_IDENT, ID_VAL);
      rd(2'h0, `PFC_OFS_IDENT, `PFC_RD_UNMAPPED);
      rd(2'h3, `PFC_OFS_CMD, `PFC_RD_UNMAPPED);
      rd(2'h0, 8'h06, `PFC_RD_UNMAPPED);
      $display("test register access done");
      // per-function gating of claims, requests, interrupts, palette
      wr(2'h0, `PFC_OFS_CMD, 2'h3, 16'h0001);
      wr(2'h1, `PFC_OFS_CMD, 2'h3, 16'h0402);
      wr(2'h2, `PFC_OFS_CMD, 2'h3, 16'h0024);
      pulse_hits(3'h7);
      check({1'b0, io_claim, mem_claim, bus_req, int_assert, palette_claim}, 16'h152b);
      check({snoop_valid, special_claim, init_use_winv, 3'h0, snoop_data}, 16'h805c);
      // feature enable falling clears the interrupt block bit
      rev23_features_enable = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rd(2'h1, `PFC_OFS_CMD, 16'h0002);
      rev23_features_enable = 1'b1;
      $display("test gating done");
      // parity error response across functions
      par(1'b0, 1'b1, 16'h0000);
      wr(2'h2, `PFC_OFS_CMD, 2'h3, 16'h0124);
      par(1'b1, 1'b0, 16'h0000);
      wr(2'h0, `PFC_OFS_CMD, 2'h3, 16'h0041);
      par(1'b1, 1'b0, 16'h0002);
      par(1'b0, 1'b1, 16'h0003);
      rd(2'h2, `PFC_OFS_CMD, 16'h0124);
      $display("test parity done");
      // reset in mid-run returns every enable to zero
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      rd(2'h0, `PFC_OFS_CMD, 16'h0000);
      rd(2'h2, `PFC_OFS_CMD, 16'h0000);
      $display("test reset done");
      stop_test();
   end
endmodule
